// ===== elb_pkg.sv
package elb_pkg;

  // ==========================================================================
  // Widths and geometry
  // ==========================================================================
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 6;
  localparam int NUM_SPACES = 8;
  localparam int SPACE_LSB = 17;
  localparam int WAIT_W = 3;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [5:0] REG_MODE = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h01;
  localparam logic [5:0] REG_PORT_OUT = 6'h04;
  localparam logic [5:0] REG_PORT_DIR = 6'h08;
  localparam logic [5:0] REG_PORT_PIN = 6'h0C;
  localparam logic [5:0] REG_SPACE_CFG = 6'h10;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int MODE_AWAIT_BIT = 4;
  localparam int CFG_WIDE_BIT = 8;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] SPAN_MAX = 3'h7;
  localparam logic [2:0] SPAN_64K = 3'h5;
  localparam logic [7:0] PORT_RESET = 8'h00;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] byteEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } elb_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
  } elb_rsp_t;

  typedef struct packed {
    logic wide;
    logic [WAIT_W-1:0] waits;
  } elb_cfg_t;

  localparam elb_cfg_t CFG_RESET = '{wide: 1'b0, waits: 3'h7};

  typedef struct packed {
    logic [7:0] p4;
    logic [7:0] p5;
    logic [3:0] p6;
    logic [3:0] p9;
  } elb_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_ADDR,
    ST_AWAIT,
    ST_DATA,
    ST_END
  } elb_state_t;

  // Address pins claimed by a span code, port 5 then port 6
  function automatic logic [11:0] elb_bus_mask(input logic [2:0] span);
    logic [12:0] one;
    one = 13'h0001 << {span - 3'h1, 1'b0};
    elb_bus_mask = 12'(one - 13'h0001);
  endfunction

endpackage

// ===== elb_cfg_mem.sv
`timescale 1ns/1ps
module elb_cfg_mem
  import elb_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire elb_cfg_t wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output elb_cfg_t rdData
);

  generate
    if (DEPTH < 2) begin : g_chk
      $error("elb_cfg_mem needs at least two entries");
    end
  endgenerate

  elb_cfg_t mem_q [DEPTH];
  elb_cfg_t rdData_q;

  // ==========================================================================
  // Storage, one entry per memory space
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= CFG_RESET;
      end
    end else if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= CFG_RESET;
    end else begin
      rdData_q <= mem_q[rdAddr];
    end
  end

  assign rdData = rdData_q;

endmodule

// ===== elb_local_bus.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] External bus reaches a memory and I/O space of up to one megabyte.
// [RULE2] External space selectable in seven steps, 256 bytes up to 1M bytes.
// [RULE3] Mode field chooses general-purpose ports or external bus pin functions.
// [RULE4] In expansion mode port 4 carries multiplexed address/data low byte.
// [RULE5] Port 9 bits 0..3 give read, low write, high write, address strobe.
// [RULE6] Port 5 bus pins output address bits 8 to 15.
// [RULE7] Port 5 and 6 pins outside the selected space stay general-purpose.
// [RULE8] Each step adds two address pins, ending with lines 16-19.
// [RULE9] Software selects at least 64K when any space uses 16-bit width.
// [RULE10] One megabyte split into eight spaces, each with own wait and width.
// [RULE11] Programmable per-space wait states while read or write strobe active.
// [RULE12] Address wait option lengthens the address strobe for every space.
// [RULE13] Each space independently uses an 8-bit or 16-bit data bus.
// [RULE14] External logic latches low address on address strobe, decodes upper lines.
// [RULE15] 16-bit space: low strobe for even byte, high for odd, both for word.
module elb_local_bus
  import elb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  input wire elb_req_t req,
  output logic reqReady,
  output elb_rsp_t rsp,
  input wire elb_pins_t pinIn,
  output elb_pins_t pinOut,
  output elb_pins_t pinOe
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  elb_state_t state_q;
  elb_state_t state_d;
  logic [3:0] modeField_q;
  logic addrWait_q;
  logic [7:0] portOut_q [4];
  logic [7:0] portDir_q [4];
  elb_pins_t pinMeta_q;
  elb_pins_t pinSync_q;
  elb_pins_t pinOut_q;
  elb_pins_t pinOe_q;
  elb_pins_t pinOut_d;
  elb_pins_t pinOe_d;
  elb_req_t curReq_q;
  elb_cfg_t curCfg_q;
  elb_cfg_t cfgRd;
  logic [WAIT_W-1:0] waitCnt_q;
  logic laneHi_q;
  logic [DATA_W-1:0] rdAcc_q;
  logic [DATA_W-1:0] regRdata_q;
  logic reqReady_q;
  elb_rsp_t rsp_q;
  logic [2:0] lastSpace_q;
  logic expOn;
  logic [2:0] spanCode;
  logic [11:0] busMask;
  logic [ADDR_W-1:0] busAddr;
  logic secondPhase;
  logic isWrite;
  logic cfgWr;
  logic [2:0] cfgRaddr;
  logic [11:0] gpioHiOut;
  logic [11:0] gpioHiOe;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  assign expOn = (modeField_q != MODE_RESET); // RULE3
  // Codes above seven behave as the full megabyte
  assign spanCode = (modeField_q > {1'b0, SPAN_MAX}) ? SPAN_MAX : modeField_q[2:0]; // RULE2
  assign busMask = elb_bus_mask(spanCode); // RULE8
  assign isWrite = curReq_q.write;
  // Wide spaces put the odd byte on the high lane; narrow ones step lanes
  assign busAddr = {curReq_q.addr[ADDR_W-1:1],
                    curCfg_q.wide ? (curReq_q.byteEn == 2'b10) : laneHi_q}; // RULE1
  assign secondPhase = !curCfg_q.wide && (curReq_q.byteEn == 2'b11) && !laneHi_q; // RULE13

  // ==========================================================================
  // Per-space configuration table
  // ==========================================================================
  assign cfgWr = regWr && (regAddr[5:3] == REG_SPACE_CFG[5:3]);
  assign cfgRaddr = (state_q == ST_IDLE) ? req.addr[SPACE_LSB+2:SPACE_LSB]
                                         : curReq_q.addr[SPACE_LSB+2:SPACE_LSB]; // RULE10

  elb_cfg_mem #(
    .DEPTH(NUM_SPACES)
  ) u_cfg (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wrEn(cfgWr),
    .wrAddr(regAddr[2:0]),
    .wrData('{wide: regWdata[CFG_WIDE_BIT], waits: regWdata[WAIT_W-1:0]}),
    .rdAddr(cfgRaddr),
    .rdData(cfgRd)
  );

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeField_q <= MODE_RESET;
      addrWait_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        portOut_q[i] <= PORT_RESET;
        portDir_q[i] <= PORT_RESET;
      end
    end else if (regWr) begin
      if (regAddr == REG_MODE) begin
        modeField_q <= regWdata[3:0];
        addrWait_q <= regWdata[MODE_AWAIT_BIT]; // RULE12
      end else if (regAddr[5:2] == REG_PORT_OUT[5:2]) begin
        portOut_q[regAddr[1:0]] <= regWdata[7:0];
      end else if (regAddr[5:2] == REG_PORT_DIR[5:2]) begin
        portDir_q[regAddr[1:0]] <= regWdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Register reads
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_q <= '0;
    end else if (regRd) begin
      if (regAddr == REG_MODE) begin
        regRdata_q <= {11'h000, addrWait_q, modeField_q};
      end else if (regAddr == REG_STATUS) begin
        regRdata_q <= {9'h000, lastSpace_q, state_q, (state_q != ST_IDLE)};
      end else if (regAddr[5:2] == REG_PORT_OUT[5:2]) begin
        regRdata_q <= {8'h00, portOut_q[regAddr[1:0]]};
      end else if (regAddr[5:2] == REG_PORT_DIR[5:2]) begin
        regRdata_q <= {8'h00, portDir_q[regAddr[1:0]]};
      end else if (regAddr == REG_PORT_PIN) begin
        regRdata_q <= {8'h00, pinSync_q.p4};
      end else if (regAddr == REG_PORT_PIN + 6'h01) begin
        regRdata_q <= {8'h00, pinSync_q.p5};
      end else if (regAddr == REG_PORT_PIN + 6'h02) begin
        regRdata_q <= {12'h000, pinSync_q.p6};
      end else if (regAddr == REG_PORT_PIN + 6'h03) begin
        regRdata_q <= {12'h000, pinSync_q.p9};
      end else begin
        regRdata_q <= '0;
      end
    end
  end

  // ==========================================================================
  // Pin input synchroniser
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // ==========================================================================
  // Bus cycle sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req.valid && expOn) begin
          state_d = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        state_d = ST_ADDR;
      end
      ST_ADDR: begin
        state_d = addrWait_q ? ST_AWAIT : ST_DATA; // RULE12
      end
      ST_AWAIT: begin
        state_d = ST_DATA;
      end
      ST_DATA: begin
        if (waitCnt_q == '0) begin
          state_d = ST_END; // RULE11
        end
      end
      ST_END: begin
        state_d = secondPhase ? ST_ADDR : ST_IDLE; // RULE13
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      reqReady_q <= 1'b0;
    end else begin
      state_q <= state_d;
      reqReady_q <= (state_d == ST_IDLE);
    end
  end

  // Transfer context, lane stepping and wait counting
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      curReq_q <= '0;
      curCfg_q <= CFG_RESET;
      waitCnt_q <= '0;
      laneHi_q <= 1'b0;
      lastSpace_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req.valid && expOn) begin
            curReq_q <= req;
            laneHi_q <= !req.byteEn[0];
            lastSpace_q <= cfgRaddr;
          end
        end
        ST_LOOKUP: begin
          curCfg_q <= cfgRd; // RULE10
        end
        ST_ADDR: begin
          waitCnt_q <= curCfg_q.waits; // RULE11
        end
        ST_DATA: begin
          if (waitCnt_q != '0) begin
            waitCnt_q <= waitCnt_q - 3'h1;
          end
        end
        ST_END: begin
          if (secondPhase) begin
            laneHi_q <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data capture on the last strobe cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdAcc_q <= '0;
    end else if (state_q == ST_IDLE) begin
      rdAcc_q <= '0;
    end else if (state_q == ST_DATA && waitCnt_q == '0 && !isWrite) begin
      if (curCfg_q.wide) begin
        rdAcc_q <= {pinSync_q.p5, pinSync_q.p4}; // RULE13
      end else if (laneHi_q) begin
        rdAcc_q[15:8] <= pinSync_q.p4;
      end else begin
        rdAcc_q[7:0] <= pinSync_q.p4;
      end
    end
  end

  // Answer to the requester
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack <= 1'b0;
      rsp_q.err <= 1'b0;
      if (state_q == ST_IDLE && req.valid && !expOn) begin
        rsp_q.ack <= 1'b1;
        rsp_q.err <= 1'b1;
        rsp_q.rdata <= '0;
      end else if (state_q == ST_END && !secondPhase) begin
        rsp_q.ack <= 1'b1;
        rsp_q.rdata <= isWrite ? '0 : rdAcc_q;
      end
    end
  end

  // ==========================================================================
  // Pin function multiplexing
  // ==========================================================================
  assign gpioHiOut = {portOut_q[2][3:0], portOut_q[1]};
  assign gpioHiOe = {portDir_q[2][3:0], portDir_q[1]};

  always_comb begin
    pinOut_d.p4 = portOut_q[0];
    pinOe_d.p4 = portDir_q[0];
    {pinOut_d.p6, pinOut_d.p5} = gpioHiOut;
    {pinOe_d.p6, pinOe_d.p5} = gpioHiOe;
    pinOut_d.p9 = portOut_q[3][3:0];
    pinOe_d.p9 = portDir_q[3][3:0];
    if (expOn) begin
      // Unclaimed high pins keep their port function
      {pinOut_d.p6, pinOut_d.p5} = (busMask & busAddr[19:8]) | (~busMask & gpioHiOut); // RULE7
      {pinOe_d.p6, pinOe_d.p5} = busMask | gpioHiOe; // RULE6
      pinOe_d.p4 = 8'h00;
      if (state_q == ST_ADDR || state_q == ST_AWAIT) begin
        pinOut_d.p4 = busAddr[7:0]; // RULE4
        pinOe_d.p4 = 8'hFF;
      end else if (state_q == ST_DATA && isWrite) begin
        pinOut_d.p4 = (!curCfg_q.wide && laneHi_q) ? curReq_q.wdata[15:8]
                                                  : curReq_q.wdata[7:0];
        pinOe_d.p4 = 8'hFF;
      end
      // Wide data phase turns port 5 into the upper data lane
      if (state_q == ST_DATA && curCfg_q.wide) begin
        pinOut_d.p5 = curReq_q.wdata[15:8];
        pinOe_d.p5 = isWrite ? 8'hFF : 8'h00;
      end
      pinOe_d.p9 = 4'hF;
      pinOut_d.p9[0] = !(state_q == ST_DATA && !isWrite); // RULE5
      pinOut_d.p9[1] = !(state_q == ST_DATA && isWrite
                         && (!curCfg_q.wide || curReq_q.byteEn[0])); // RULE15
      pinOut_d.p9[2] = !(state_q == ST_DATA && isWrite
                         && curCfg_q.wide && curReq_q.byteEn[1]); // RULE15
      pinOut_d.p9[3] = (state_q == ST_ADDR || state_q == ST_AWAIT); // RULE12
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign regRdata = regRdata_q;
  assign reqReady = reqReady_q;
  assign rsp = rsp_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic [3:0] rdLowLen_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdLowLen_q <= '0;
    end else if (!pinOut_q.p9[0]) begin
      rdLowLen_q <= rdLowLen_q + 4'h1;
    end else begin
      rdLowLen_q <= '0;
    end
  end

  sequence s_stretched;
    state_q == ST_AWAIT ##1 state_q == ST_DATA;
  endsequence

  sequence s_secondAddr;
    state_q == ST_ADDR && laneHi_q;
  endsequence

  property p_addrWait;
    (state_q == ST_ADDR && addrWait_q) |=> s_stretched;
  endproperty
  a_addrWait: assert property (p_addrWait) else $error("address wait not inserted"); // RULE12

  property p_noAddrWait;
    (state_q == ST_ADDR && !addrWait_q) |=> state_q == ST_DATA ##1 !pinOut_q.p9[3];
  endproperty
  a_noAddrWait: assert property (p_noAddrWait) else $error("address strobe too long"); // RULE12

  property p_strobePins;
    state_q == ST_ADDR |=> pinOut_q.p9[3] && pinOut_q.p9[0] && pinOe_q.p9 == 4'hF;
  endproperty
  a_strobePins: assert property (p_strobePins) else $error("strobe pins wrong in address phase"); // RULE5

  property p_adLow;
    state_q == ST_ADDR |=> pinOut_q.p4 == $past(busAddr[7:0]) && pinOe_q.p4 == 8'hFF;
  endproperty
  a_adLow: assert property (p_adLow) else $error("low address not on port 4"); // RULE4

  property p_rdWidth;
    (expOn && $past(state_q == ST_END) && $rose(pinOut_q.p9[0]))
      |-> rdLowLen_q == {1'b0, curCfg_q.waits} + 4'h1;
  endproperty
  a_rdWidth: assert property (p_rdWidth) else $error("read strobe length differs from waits"); // RULE11

  property p_wordWrite;
    (state_q == ST_DATA && isWrite && curCfg_q.wide && curReq_q.byteEn == 2'b11)
      |=> pinOut_q.p9[2:1] == 2'b00;
  endproperty
  a_wordWrite: assert property (p_wordWrite) else $error("word write missing a strobe"); // RULE15

  property p_twoPhases;
    (state_q == ST_END && secondPhase) |=> s_secondAddr;
  endproperty
  a_twoPhases: assert property (p_twoPhases) else $error("narrow word not split"); // RULE13

  property p_gpioKept;
    (expOn && spanCode <= SPAN_64K && $stable(spanCode))
      |=> pinOe_q.p6 == $past(portDir_q[2][3:0]);
  endproperty
  a_gpioKept: assert property (p_gpioKept) else $error("port 6 taken below 256K"); // RULE7

  property p_fullSpan;
    (expOn && spanCode == SPAN_MAX) |=> pinOe_q.p6 == 4'hF && pinOut_q.p6 == $past(busAddr[19:16]);
  endproperty
  a_fullSpan: assert property (p_fullSpan) else $error("upper lines wrong at 1M"); // RULE8

  property p_portMode;
    !expOn |=> pinOe_q.p9 == $past(portDir_q[3][3:0]) && pinOe_q.p4 == $past(portDir_q[0]);
  endproperty
  a_portMode: assert property (p_portMode) else $error("port mode pins not general-purpose"); // RULE3

endmodule

// ===== elb_mem_model.sv
`timescale 1ns/1ps
module elb_mem_model
  import elb_pkg::*;
(
  input wire logic ref_clk,
  input wire elb_pins_t pinOut,
  input wire elb_pins_t pinOe,
  output elb_pins_t pinLevel
);
  // ==========================================================================
  // Byte store behind the bus, low address latched from the strobe
  // ==========================================================================
  logic [7:0] mem [0:4095];
  logic [19:0] latAddr = '0;
  elb_pins_t lastLvl = '0;
  elb_pins_t drv;
  logic rdAct;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  assign rdAct = pinOe.p9[0] && !pinOut.p9[0];

  // Undriven lines show the inverse of their last level; during a read ports 4 and 5 show the addressed bytes
  always_comb begin
    drv = ~lastLvl;
    if (rdAct) begin
      drv.p4 = mem[latAddr[11:0]];
      drv.p5 = mem[latAddr[11:0] | 12'h001];
    end
    pinLevel = (pinOe & pinOut) | (~pinOe & drv);
  end

  always @(posedge ref_clk) begin
    lastLvl <= pinLevel;
    if (pinOe.p9[3] && pinOut.p9[3]) begin
      latAddr <= {pinLevel.p6 & pinOe.p6, pinLevel.p5 & pinOe.p5, pinLevel.p4};
    end
    if (pinOe.p9[1] && !pinOut.p9[1]) mem[latAddr[11:0]] <= pinLevel.p4;
    if (pinOe.p9[2] && !pinOut.p9[2]) mem[latAddr[11:0] | 12'h001] <= pinLevel.p5;
  end
endmodule

// ===== external_local_bus_interface_test.sv
`timescale 1ns/1ps
module external_local_bus_interface_test
  import elb_pkg::*;
;
  typedef struct packed {
    logic [3:0] mode;
    logic aw;
    logic wide;
    logic [2:0] waits;
    logic wr;
    logic [1:0] be;
    logic [19:0] addr;
    logic [15:0] data;
  } elb_row_t;

  logic ref_clk, arst_n, regWr, regRd, reqReady;
  logic [REG_AW-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, d;
  elb_req_t req;
  elb_rsp_t rsp, s;
  elb_pins_t pinIn, pinOut, pinOe;
  int bad_count = 0, total_checks = 0, cycles = 0;
  int rdCnt, lwrCnt, hwrCnt, astbCnt, ph, st;
  logic [7:0] astbP4;
  logic [11:0] m;
  elb_row_t r;

  // Reads need three or more waits to clear the pin synchroniser
  elb_row_t rows [10] = '{
    '{4'h7, 1'b0, 1'b1, 3'h3, 1'b1, 2'h3, 20'h20010, 16'h1234},
    '{4'h7, 1'b0, 1'b1, 3'h3, 1'b0, 2'h3, 20'h20010, 16'h1234},
    '{4'h7, 1'b1, 1'b0, 3'h3, 1'b1, 2'h3, 20'h60020, 16'hBEEF},
    '{4'h7, 1'b1, 1'b0, 3'h3, 1'b0, 2'h3, 20'h60020, 16'hBEEF},
    '{4'h5, 1'b0, 1'b1, 3'h0, 1'b1, 2'h2, 20'h00030, 16'hAB00},
    '{4'h5, 1'b0, 1'b1, 3'h1, 1'b1, 2'h0, 20'h00030, 16'h0000},
    '{4'h6, 1'b1, 1'b1, 3'h3, 1'b1, 2'h1, 20'h21040, 16'h0055},
    '{4'h6, 1'b1, 1'b1, 3'h3, 1'b0, 2'h3, 20'h21040, 16'h0055},
    '{4'h2, 1'b0, 1'b0, 3'h7, 1'b1, 2'h1, 20'h00104, 16'h0077},
    '{4'h2, 1'b0, 1'b0, 3'h7, 1'b0, 2'h3, 20'h00104, 16'h0077}
  };

  elb_local_bus uut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .req(req),
    .reqReady(reqReady), .rsp(rsp), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  elb_mem_model partner (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinIn));

  always #5 ref_clk = ~ref_clk;

  // ==========================================================================
  // Strobe monitor and hang guard
  // ==========================================================================
  always @(posedge ref_clk) begin
    if (pinOe.p9[0] && !pinOut.p9[0]) rdCnt++;
    if (pinOe.p9[1] && !pinOut.p9[1]) lwrCnt++;
    if (pinOe.p9[2] && !pinOut.p9[2]) hwrCnt++;
    if (pinOe.p9[3] && pinOut.p9[3]) begin
      astbCnt++;
      astbP4 = pinOut.p4;
    end
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWrite(input logic [5:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [5:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  task automatic xfer(input elb_row_t t, output elb_rsp_t o);
    int n;
    rdCnt = 0;
    lwrCnt = 0;
    hwrCnt = 0;
    astbCnt = 0;
    @(posedge ref_clk);
    req <= '{valid: 1'b1, write: t.wr, byteEn: t.be, addr: t.addr, wdata: t.data};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    req.valid <= 1'b0;
    n = 0;
    #1;
    while (rsp.ack !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    o = rsp;
    check("ack", 24'h1, {23'h0, rsp.ack});
  endtask

  function automatic logic [11:0] spanMask(input logic [3:0] mode);
    int k;
    k = (mode > 7) ? 7 : mode;
    spanMask = (k == 0) ? 12'h000 : 12'((1 << (2 * (k - 1))) - 1);
  endfunction

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    req = '0;
    repeat (2) @(posedge ref_clk);
    #1 check("oe in reset", 24'h0, pinOe);
    check("ready in reset", 24'h0, {23'h0, reqReady});
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 regRead(REG_MODE, d);
    check("mode reset", 24'(MODE_RESET), 24'(d));
    foreach (rows[i]) begin
      r = rows[i];
      regWrite(REG_MODE, {11'h000, r.aw, r.mode});
      if (r.wr) regWrite(REG_SPACE_CFG | {3'h0, r.addr[19:17]}, {7'h00, r.wide, 5'h00, r.waits});
      xfer(r, s);
      ph = (!r.wide && r.be == 2'h3) ? 2 : 1;
      st = ph * (r.waits + 1);
      m = spanMask(r.mode);
      if (r.wr) begin
        check("low write", 24'(r.wide ? (r.be[0] ? r.waits + 1 : 0) : st), 24'(lwrCnt));
        check("high write", 24'((r.wide && r.be[1]) ? r.waits + 1 : 0), 24'(hwrCnt));
      end else begin
        check("read strobe", 24'(st), 24'(rdCnt));
        check("read data", 24'(r.data), 24'(s.rdata));
      end
      check("addr strobe", 24'(ph * (1 + r.aw)), 24'(astbCnt));
      check("low addr", 24'((r.be == 2'h2 || (!r.wide && r.be == 2'h3)) ?
        (r.addr[7:0] | 8'h01) : r.addr[7:0]), 24'(astbP4));
      check("strobe oe", 24'hF, 24'(pinOe.p9));
      check("p5 oe", 24'(m[7:0]), 24'(pinOe.p5));
      check("p6 oe", 24'(m[11:8]), 24'(pinOe.p6));
      check("upper addr", 24'(r.addr[19:16] & m[11:8]), 24'(pinOut.p6 & m[11:8]));
      if (!r.wide) check("mid addr", 24'(r.addr[15:8] & m[7:0]), 24'(pinOut.p5 & m[7:0]));
      regRead(REG_STATUS, d);
      check("last space", 24'({r.addr[19:17], 4'h0}), 24'(d));
    end
    regWrite(6'h3F, 16'hFFFF);
    regRead(REG_MODE, d);
    check("unmapped write", 24'h2, 24'(d));
    regRead(6'h20, d);
    check("unmapped read", 24'h0, 24'(d));
    regRead(REG_SPACE_CFG, d);
    check("cfg read", 24'h0, 24'(d));
    regWrite(REG_PORT_DIR | 6'h01, 16'h00FF);
    regWrite(REG_PORT_OUT | 6'h01, 16'h00A5);
    repeat (4) @(posedge ref_clk);
    #1 check("gp oe", 24'hFF, 24'(pinOe.p5));
    check("gp out", 24'hA4, 24'(pinOut.p5 & 8'hFC));
    regRead(REG_PORT_PIN | 6'h01, d);
    check("gp pin", 24'hA4, 24'(d[7:0] & 8'hFC));
    regWrite(REG_PORT_DIR | 6'h01, 16'h0000);
    regWrite(REG_MODE, 16'h0007);
    xfer('{4'h7, 1'b0, 1'b0, 3'h0, 1'b1, 2'h1, 20'hA0008, 16'h0011}, s);
    check("reset waits", 24'h8, 24'(lwrCnt));
    check("reset width", 24'h0, 24'(hwrCnt));
    regWrite(REG_MODE, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1 check("port mode oe", 24'h0, pinOe);
    xfer('{4'h0, 1'b0, 1'b0, 3'h0, 1'b0, 2'h3, 20'h00010, 16'h0000}, s);
    check("port mode err", 24'h1, {23'h0, s.err});
    check("port mode strobes", 24'h0, 24'(rdCnt + astbCnt));
    regWrite(REG_MODE, 16'h0007);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("oe in reset", 24'h0, pinOe);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 regRead(REG_MODE, d);
    check("mode after reset", 24'(MODE_RESET), 24'(d));
    summarize();
  end
endmodule
